// *** sleep_mode_controller.sv ***
// Sleep-mode controller: clock-domain gating, wake qualification and
// wake-up sequencing for a small microcontroller core.
// Assumes core and wake sources are on clk; registers via AXI4-Lite.
`timescale 1ns/1ps

module sleep_mode_controller #(
  parameter int PD_DELAY_MAX = 65535
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     srst,
  // AXI4-Lite write address
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [7:0]               s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  // AXI4-Lite write response
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  output logic [1:0]                    s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  input  wire logic [7:0]               s_axi_araddr,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  // Core side
  input  wire logic                     sleep_instr,
  output logic                          core_halt,
  output logic                          irq_service,
  output logic                          reset_restart,
  // Wake sources, already in clk domain
  input  wire logic [sleep_pkg::WAKE_W-1:0] wake_req,
  input  wire logic                     sys_reset_req,
  // Clock enables and converter start
  output sleep_pkg::clk_en_t            clk_en,
  output logic                          conv_start,
  output logic [2:0]                    active_mode
);

  logic [7:0]  sleep_ctrl_r;
  logic [13:0] core_ctrl_r;
  sleep_pkg::state_t state_r;
  logic [sleep_pkg::CNT_W-1:0] cnt_r;
  logic [2:0]  mode_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        wr_fire;
  logic [2:0]  sel;
  logic        mode_ok;
  logic        enter;
  logic        t2_async;
  logic        t2_sync;
  logic        t2_on;
  logic        gie;
  logic [1:0]  t2_mask;
  logic [3:0]  fuse;
  logic [sleep_pkg::WAKE_W-1:0] allow;
  logic        wake;
  logic [sleep_pkg::CNT_W-1:0] startup_cyc;
  logic [sleep_pkg::CNT_W-1:0] pd_cyc;

  assign sel      = sleep_ctrl_r[sleep_pkg::SM_LSB +: 3];
  assign t2_async = core_ctrl_r[sleep_pkg::T2_ASYNC_BIT];
  assign t2_sync  = core_ctrl_r[sleep_pkg::T2_SYNC_BIT];
  assign t2_on    = core_ctrl_r[sleep_pkg::T2_ON_BIT];
  assign gie      = core_ctrl_r[sleep_pkg::GIE_BIT];
  assign t2_mask  = core_ctrl_r[sleep_pkg::T2_MASK_LSB +: 2];
  assign fuse     = core_ctrl_r[sleep_pkg::FUSE_LSB +: 4];

  // Mode legality; standby only with a crystal option
  always_comb begin
    case (sel)
      sleep_pkg::MODE_IDLE,
      sleep_pkg::MODE_CONV_NR,
      sleep_pkg::MODE_PWR_DOWN,
      sleep_pkg::MODE_PWR_SAVE: mode_ok = 1'b1;
      sleep_pkg::MODE_STANDBY:
        mode_ok = core_ctrl_r[sleep_pkg::XTAL_BIT];
      default: mode_ok = 1'b0;
    endcase
  end

  // Sleep entry needs enable at the instruction
  assign enter = (state_r == sleep_pkg::ST_RUN) && sleep_instr &&
                 sleep_ctrl_r[sleep_pkg::SE_BIT] && mode_ok;

  // Wake qualification per mode
  always_comb begin
    allow = '0;
    case (mode_r)
      sleep_pkg::MODE_IDLE: begin
        allow = '1;
      end
      sleep_pkg::MODE_CONV_NR: begin
        allow = '1;
        allow[sleep_pkg::W_OTHER] = 1'b0;
      end
      sleep_pkg::MODE_PWR_SAVE: begin
        allow[sleep_pkg::W_WDT]   = 1'b1;
        allow[sleep_pkg::W_TWI]   = 1'b1;
        allow[sleep_pkg::W_PCINT] = 1'b1;
        allow[sleep_pkg::W_T2_OVF] = t2_on & gie & t2_mask[0];
        allow[sleep_pkg::W_T2_CMP] = t2_on & gie & t2_mask[1];
      end
      default: begin
        allow[sleep_pkg::W_WDT]   = 1'b1;
        allow[sleep_pkg::W_TWI]   = 1'b1;
        allow[sleep_pkg::W_PCINT] = 1'b1;
      end
    endcase
    // Edge-triggered external irqs wake only from idle
    if (mode_r != sleep_pkg::MODE_IDLE) begin
      allow[sleep_pkg::W_EXT_IRQ_0] =
        core_ctrl_r[sleep_pkg::EXT_IRQ_0_LEVEL_BIT];
      allow[sleep_pkg::W_EXT_IRQ_1] =
        core_ctrl_r[sleep_pkg::EXT_IRQ_1_LEVEL_BIT];
    end
  end

  // Level sources are sampled only while asleep, so they must persist
  assign wake = |(wake_req & allow);

  // Deep-mode delay grows with the fuses; the parameter is a hard ceiling
  assign pd_cyc = sleep_pkg::CNT_W'(sleep_pkg::PD_DELAY_BASE_CYC *
                                    (int'(fuse) + 1));

  // Restart delay: standby fixed, deep modes scale with fuses
  always_comb begin
    case (mode_r)
      sleep_pkg::MODE_STANDBY:
        startup_cyc = sleep_pkg::CNT_W'(sleep_pkg::STANDBY_CYCLES);
      sleep_pkg::MODE_PWR_DOWN,
      sleep_pkg::MODE_PWR_SAVE:
        startup_cyc = (pd_cyc > sleep_pkg::CNT_W'(PD_DELAY_MAX)) ?
          sleep_pkg::CNT_W'(PD_DELAY_MAX) : pd_cyc;
      default: startup_cyc = sleep_pkg::CNT_W'(1);
    endcase
  end

  // AXI4-Lite write channel capture
  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_r <= 1'b1;
      awaddr_r  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      w_hold_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_r <= 1'b1;
      wdata_r  <= s_axi_wdata;
      wstrb_r  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_hold_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_hold_r && !(s_axi_wvalid && s_axi_wready);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r == sleep_pkg::SLEEP_CTRL_ADDR ||
                       awaddr_r == sleep_pkg::CORE_CTRL_ADDR ||
                       awaddr_r == sleep_pkg::STATUS_ADDR) ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; bits 7..4 of sleep control never stored
  always_ff @(posedge clk) begin
    if (srst) begin
      sleep_ctrl_r <= sleep_pkg::SLEEP_CTRL_RESET;
      core_ctrl_r  <= sleep_pkg::CORE_CTRL_RESET;
    end else if (wr_fire) begin
      if (awaddr_r == sleep_pkg::SLEEP_CTRL_ADDR && wstrb_r[0])
        sleep_ctrl_r <= wdata_r[7:0] & sleep_pkg::SLEEP_CTRL_WMASK;
      if (awaddr_r == sleep_pkg::CORE_CTRL_ADDR) begin
        if (wstrb_r[0])
          core_ctrl_r[7:0] <= wdata_r[7:0];
        if (wstrb_r[1])
          core_ctrl_r[13:8] <= wdata_r[13:8];
      end
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= 2'h0;
      case (s_axi_araddr)
        sleep_pkg::SLEEP_CTRL_ADDR:
          s_axi_rdata <= {24'h00_0000, sleep_ctrl_r};
        sleep_pkg::CORE_CTRL_ADDR:
          s_axi_rdata <= {18'h0_0000, core_ctrl_r};
        sleep_pkg::STATUS_ADDR:
          s_axi_rdata <= {23'h00_0000, mode_r, state_r};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // Sleep sequencer; it touches no core storage, only clocks
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= sleep_pkg::ST_RUN;
      cnt_r   <= '0;
      mode_r  <= sleep_pkg::MODE_IDLE;
    end else begin
      case (state_r)
        sleep_pkg::ST_RUN: begin
          if (enter) begin
            state_r <= sleep_pkg::ST_SLEEP;
            mode_r  <= sel;
          end
        end
        sleep_pkg::ST_SLEEP: begin
          if (sys_reset_req) begin
            state_r <= sleep_pkg::ST_RESTART;
          end else if (wake) begin
            state_r <= sleep_pkg::ST_STARTUP;
            cnt_r   <= startup_cyc;
          end
        end
        sleep_pkg::ST_STARTUP: begin
          if (cnt_r <= sleep_pkg::CNT_W'(1)) begin
            state_r <= sleep_pkg::ST_HALT;
            cnt_r   <= sleep_pkg::CNT_W'(sleep_pkg::HALT_CYCLES);
          end else begin
            cnt_r <= cnt_r - sleep_pkg::CNT_W'(1);
          end
        end
        sleep_pkg::ST_HALT: begin
          if (cnt_r <= sleep_pkg::CNT_W'(1))
            state_r <= sleep_pkg::ST_SERVICE;
          else
            cnt_r <= cnt_r - sleep_pkg::CNT_W'(1);
        end
        sleep_pkg::ST_SERVICE: state_r <= sleep_pkg::ST_RUN;
        sleep_pkg::ST_RESTART: state_r <= sleep_pkg::ST_RUN;
        default: state_r <= sleep_pkg::ST_RUN;
      endcase
    end
  end

  // Core handshake outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      core_halt     <= 1'b0;
      irq_service   <= 1'b0;
      reset_restart <= 1'b0;
      active_mode   <= sleep_pkg::MODE_IDLE;
    end else begin
      // Released with the service or restart pulse, never a cycle apart
      core_halt     <= enter || (state_r != sleep_pkg::ST_RUN &&
                                 state_r != sleep_pkg::ST_SERVICE &&
                                 state_r != sleep_pkg::ST_RESTART &&
                                 !(state_r == sleep_pkg::ST_SLEEP &&
                                   sys_reset_req) &&
                                 !(state_r == sleep_pkg::ST_HALT &&
                                   cnt_r <= sleep_pkg::CNT_W'(1)));
      irq_service   <= state_r == sleep_pkg::ST_HALT &&
                       cnt_r <= sleep_pkg::CNT_W'(1);
      reset_restart <= state_r == sleep_pkg::ST_SLEEP &&
                       sys_reset_req;
      active_mode   <= enter ? sel : mode_r;
    end
  end

  // Converter auto-start on entry
  always_ff @(posedge clk) begin
    if (srst)
      conv_start <= 1'b0;
    else
      conv_start <= enter && core_ctrl_r[sleep_pkg::CONV_EN_BIT] &&
                    (sel == sleep_pkg::MODE_IDLE ||
                     sel == sleep_pkg::MODE_CONV_NR);
  end

  // Clock gating; gated from the entry cycle until start-up is over
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_en <= '1;
    end else if (enter || state_r == sleep_pkg::ST_SLEEP) begin
      case (enter ? sel : mode_r)
        sleep_pkg::MODE_IDLE: begin
          clk_en          <= '1;
          clk_en.core     <= 1'b0;
          clk_en.prog_mem <= 1'b0;
          clk_en.timer_osc <= t2_async;
        end
        sleep_pkg::MODE_CONV_NR: begin
          clk_en          <= '1;
          clk_en.core     <= 1'b0;
          clk_en.prog_mem <= 1'b0;
          clk_en.periph   <= 1'b0;
          clk_en.timer_osc <= t2_async;
        end
        sleep_pkg::MODE_PWR_SAVE: begin
          clk_en           <= '0;
          clk_en.async_t   <= t2_on;
          clk_en.timer_osc <= t2_on & t2_async;
          clk_en.main_osc  <= t2_on & t2_sync;
        end
        sleep_pkg::MODE_STANDBY: begin
          clk_en          <= '0;
          clk_en.main_osc <= 1'b1;
        end
        default: clk_en <= '0;
      endcase
    end else if (state_r == sleep_pkg::ST_STARTUP) begin
      clk_en          <= '1;
      clk_en.core     <= 1'b0;
      clk_en.prog_mem <= 1'b0;
    end else begin
      clk_en <= '1;
    end
  end

endmodule

// *** sleep_pkg.sv ***
// Package for the sleep-mode controller: register map, field layout,
// mode codes, wake-source indices and timing constants.
// Assumes a 40 MHz system clock and an AXI4-Lite register bus.
package sleep_pkg;

  // Register map (byte addresses)
  localparam logic [7:0] SLEEP_CTRL_ADDR  = 8'h00;
  localparam logic [7:0] CORE_CTRL_ADDR   = 8'h04;
  localparam logic [7:0] STATUS_ADDR      = 8'h08;

  // Sleep control register fields
  localparam int         SE_BIT           = 0;
  localparam int         SM_LSB           = 1;
  localparam logic [7:0] SLEEP_CTRL_RESET = 8'h00;
  localparam logic [7:0] SLEEP_CTRL_WMASK = 8'h0F;

  // Core control register fields
  localparam int         T2_ASYNC_BIT     = 0;
  localparam int         T2_SYNC_BIT      = 1;
  localparam int         T2_ON_BIT        = 2;
  localparam int         XTAL_BIT         = 3;
  localparam int         CONV_EN_BIT      = 4;
  localparam int         T2_MASK_LSB      = 5;
  localparam int         GIE_BIT          = 7;
  localparam int         EXT_IRQ_0_LEVEL_BIT   = 8;
  localparam int         EXT_IRQ_1_LEVEL_BIT   = 9;
  localparam int         FUSE_LSB         = 10;
  localparam logic [13:0] CORE_CTRL_RESET = 14'h0000;

  // Mode codes
  localparam logic [2:0] MODE_IDLE        = 3'h0;
  localparam logic [2:0] MODE_CONV_NR     = 3'h1;
  localparam logic [2:0] MODE_PWR_DOWN    = 3'h2;
  localparam logic [2:0] MODE_PWR_SAVE    = 3'h3;
  localparam logic [2:0] MODE_STANDBY     = 3'h6;

  // Wake-source indices
  localparam int W_CONV    = 0;
  localparam int W_WDT     = 1;
  localparam int W_TWI     = 2;
  localparam int W_T2_OVF  = 3;
  localparam int W_T2_CMP  = 4;
  localparam int W_NVM     = 5;
  localparam int W_EXT_IRQ_0    = 6;
  localparam int W_EXT_IRQ_1    = 7;
  localparam int W_PCINT   = 8;
  localparam int W_OTHER   = 9;
  localparam int WAKE_W    = 10;

  // Timing
  localparam int CLK_MHZ            = 40;
  localparam int HALT_CYCLES        = 4;
  localparam int STANDBY_CYCLES     = 6;
  localparam int PD_DELAY_BASE_NS   = 1000;
  localparam int PD_DELAY_BASE_CYC  = (PD_DELAY_BASE_NS * CLK_MHZ) / 1000;
  localparam int CNT_W              = 16;

  typedef enum logic [5:0] {
    ST_RUN     = 6'h01,
    ST_SLEEP   = 6'h02,
    ST_STARTUP = 6'h04,
    ST_HALT    = 6'h08,
    ST_SERVICE = 6'h10,
    ST_RESTART = 6'h20
  } state_t;

  typedef struct packed {
    logic core;
    logic prog_mem;
    logic periph;
    logic conv;
    logic async_t;
    logic main_osc;
    logic timer_osc;
  } clk_en_t;

endpackage

// *** sleep_mode_controller_properties.sv ***
// Checker for the sleep-mode controller: entry, clock gating, wake.
// Sees only the controller's core-side and clock-enable ports.
`timescale 1ns/1ps
module sleep_mode_controller_properties (
  // Clock and reset
  input wire logic               clk,
  input wire logic               srst,
  // Core side
  input wire logic               sleep_instr,
  input wire logic               core_halt,
  input wire logic               irq_service,
  input wire logic               reset_restart,
  input wire logic               sys_reset_req,
  // Clock enables
  input wire sleep_pkg::clk_en_t clk_en,
  input wire logic               conv_start,
  input wire logic [2:0]         active_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_halt_cause: assert property (
    $rose(core_halt) |-> $past(sleep_instr))
    else $error("core halted without a sleep instruction");
  a_mode_legal: assert property (
    core_halt |-> active_mode inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h6})
    else $error("halted in a reserved mode");
  a_idle_clocks: assert property (
    $rose(core_halt) && active_mode == sleep_pkg::MODE_IDLE
    |-> clk_en[6:1] == 6'h0F) else $error("idle clock gating wrong");
  a_noise_clocks: assert property (
    $rose(core_halt) && active_mode == sleep_pkg::MODE_CONV_NR
    |-> clk_en[6:1] == 6'h07) else $error("noise clock gating wrong");
  a_pdown_clocks: assert property (
    $rose(core_halt) && active_mode == sleep_pkg::MODE_PWR_DOWN
    |-> clk_en == 7'h00) else $error("power-down clocks running");
  a_psave_clocks: assert property (
    $rose(core_halt) && active_mode == sleep_pkg::MODE_PWR_SAVE
    |-> clk_en[6:3] == 4'h0) else $error("power-save clocks running");
  a_standby_clocks: assert property (
    $rose(core_halt) && active_mode == sleep_pkg::MODE_STANDBY
    |-> clk_en == 7'h02) else $error("standby clock gating wrong");
  a_conv_entry: assert property (
    conv_start |-> core_halt && active_mode inside {3'h0, 3'h1})
    else $error("conversion start outside idle or noise entry");
  a_halt_span: assert property (
    irq_service |-> !core_halt && $past(core_halt, 5) && clk_en == 7'h7F)
    else $error("wake service without full halt");
  a_reset_wins: assert property (
    $rose(sys_reset_req) && core_halt |-> ##[1:4] reset_restart)
    else $error("reset in sleep did not restart");
  a_release: assert property (
    $fell(core_halt) |-> (irq_service ^ reset_restart))
    else $error("core released without service or restart");

  cover property ($rose(core_halt) && conv_start);
  cover property (irq_service);
  cover property (reset_restart);
endmodule

bind sleep_mode_controller sleep_mode_controller_properties i_props (
  .clk(clk), .srst(srst), .sleep_instr(sleep_instr),
  .core_halt(core_halt), .irq_service(irq_service),
  .reset_restart(reset_restart), .sys_reset_req(sys_reset_req),
  .clk_en(clk_en), .conv_start(conv_start), .active_mode(active_mode));

// *** core_wake_model.sv ***
// Model of the core and the wake sources beside the controller.
// Driven by bench commands one cycle wide, on clk.
`timescale 1ns/1ps
module core_wake_model (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         srst,
  // Bench commands
  input  wire logic                         go,
  input  wire logic [sleep_pkg::WAKE_W-1:0] raise,
  input  wire logic                         drop,
  // Controller side
  input  wire logic                         irq_service,
  input  wire logic                         reset_restart,
  output logic                              sleep_instr,
  output logic [sleep_pkg::WAKE_W-1:0]      wake_req
);
  always_ff @(posedge clk) begin
    sleep_instr <= go & ~srst;
  end
  // Level held until serviced, restarted or dropped, so long restart delays still see it
  always_ff @(posedge clk) begin
    if (srst || drop || irq_service || reset_restart) begin
      wake_req <= '0;
    end else begin
      wake_req <= wake_req | raise;
    end
  end
endmodule

// *** sleep_mode_controller_tb.sv ***
// Self-checking bench for the sleep-mode controller.
// Assumes the checker is bound in and the core model drives the core side.
`timescale 1ns/1ps
module sleep_mode_controller_tb;
  localparam int PD_MAX = 63;
  localparam logic [sleep_pkg::WAKE_W-1:0] W1 = 10'h001;
  logic                         clk, srst, go, drop, sys_rst;
  logic                         awvalid, awready, wvalid, wready;
  logic                         bvalid, bready, arvalid, arready;
  logic                         rvalid, rready, sleep_instr, core_halt;
  logic                         irq_service, reset_restart, conv_start;
  logic [7:0]                   awaddr, araddr;
  logic [31:0]                  wdata, rdata, rd;
  logic [1:0]                   bresp, rresp, rsp;
  logic [sleep_pkg::WAKE_W-1:0] raise, wake_req;
  logic [2:0]                   active_mode;
  sleep_pkg::clk_en_t           clk_en;
  int                           errors, n_checks, lat0;
  int                           conv_cnt = 0;

  sleep_mode_controller #(.PD_DELAY_MAX(PD_MAX)) i_dut (
    .clk(clk), .srst(srst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .sleep_instr(sleep_instr), .core_halt(core_halt),
    .irq_service(irq_service), .reset_restart(reset_restart),
    .wake_req(wake_req), .sys_reset_req(sys_rst),
    .clk_en(clk_en), .conv_start(conv_start),
    .active_mode(active_mode));

  core_wake_model i_model (
    .clk(clk), .srst(srst), .go(go), .raise(raise), .drop(drop),
    .irq_service(irq_service), .reset_restart(reset_restart),
    .sleep_instr(sleep_instr), .wake_req(wake_req));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (conv_start === 1'h1) begin
      conv_cnt <= conv_cnt + 1;
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'h0;
    wd = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        ad = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        wd = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge clk); while (!bvalid);
    rsp = bresp;
    bready <= 1'h0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask

  // One-cycle commands to the core model
  task automatic kick(input logic [sleep_pkg::WAKE_W-1:0] r,
                      input logic g, input logic d);
    @(posedge clk);
    raise <= r;
    go <= g;
    drop <= d;
    @(posedge clk);
    raise <= '0;
    go <= 1'h0;
    drop <= 1'h0;
  endtask

  task automatic t_regs;
    axr(sleep_pkg::SLEEP_CTRL_ADDR);
    chk("sleep ctrl reset", rd, 32'h0);
    axr(sleep_pkg::STATUS_ADDR);
    chk("status reset", rd, 32'h0000_0001);
    axr(sleep_pkg::CORE_CTRL_ADDR);
    chk("core ctrl reset", rd, 32'h0);
    axw(sleep_pkg::SLEEP_CTRL_ADDR, 32'hFFFFFFFF);
    axr(sleep_pkg::SLEEP_CTRL_ADDR);
    chk("upper bits", rd, 32'h0F);
    axr(8'h0C);
    chk("unmapped read", rsp, 2'h2);
    axw(8'h0C, 32'h1);
    chk("unmapped write", rsp, 2'h2);
  endtask

  task automatic t_noop;
    logic [3:0] v[5] = '{4'h0, 4'h9, 4'hB, 4'hF, 4'hD};
    axw(sleep_pkg::CORE_CTRL_ADDR, 32'h0);
    foreach (v[i]) begin
      axw(sleep_pkg::SLEEP_CTRL_ADDR, {28'h0, v[i]});
      kick('0, 1'h1, 1'h0);
      repeat (3) @(posedge clk);
      chk("noop halt", core_halt, 1'h0);
      chk("noop clocks", clk_en, 7'h7F);
    end
  endtask

  task automatic do_sleep(input logic [2:0] m, input logic [13:0] cc,
                          input logic [6:0] ec, input int bad, good,
                          input int extra, input int cv);
    int n, c0;
    axw(sleep_pkg::CORE_CTRL_ADDR, {18'h0, cc});
    axw(sleep_pkg::SLEEP_CTRL_ADDR, {28'h0, m, 1'h1});
    c0 = conv_cnt;
    kick('0, 1'h1, 1'h0);
    repeat (3) @(posedge clk);
    chk("halted", core_halt, 1'h1);
    chk("clock enables", clk_en, ec);
    chk("mode", active_mode, m);
    chk("conversions", conv_cnt - c0, cv);
    if (bad >= 0) begin
      kick(W1 << bad, 1'h0, 1'h0);
      // Longer than the largest restart delay plus the halt
      repeat (80) @(posedge clk);
      chk("still asleep", core_halt, 1'h1);
      kick('0, 1'h0, 1'h1);
    end
    kick(W1 << good, 1'h0, 1'h0);
    n = 0;
    while (irq_service !== 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("serviced", irq_service, 1'h1);
    if (extra < 0) begin
      lat0 = n;
      chk("halt span", n, sleep_pkg::HALT_CYCLES + 3);
    end else begin
      chk("wake latency", n, lat0 + extra);
    end
    chk("awake", {core_halt, clk_en}, 8'h7F);
    axr(sleep_pkg::SLEEP_CTRL_ADDR);
    chk("ctrl kept", rd, {28'h0, m, 1'h1});
    axw(sleep_pkg::SLEEP_CTRL_ADDR, 32'h0);
  endtask

  task automatic t_reset;
    int n;
    axw(sleep_pkg::CORE_CTRL_ADDR, 32'h0);
    axw(sleep_pkg::SLEEP_CTRL_ADDR, 32'h1);
    kick('0, 1'h1, 1'h0);
    repeat (3) @(posedge clk);
    sys_rst <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (reset_restart !== 1'h1 && n < 20);
    sys_rst <= 1'h0;
    chk("restart", reset_restart, 1'h1);
    chk("no service", irq_service, 1'h0);
    chk("released", core_halt, 1'h0);
  endtask

  initial begin
    srst = 1'h1;
    {go, drop, sys_rst, awvalid, wvalid, bready} = '0;
    {arvalid, rready, awaddr, araddr, wdata, raise} = '0;
    repeat (12) @(posedge clk);
    srst <= 1'h0;
    repeat (2) @(posedge clk);
    t_regs;
    t_noop;
    do_sleep(3'h0, 14'h0010, 7'h1E, -1, sleep_pkg::W_OTHER,
             -1, 1);
    do_sleep(3'h1, 14'h0011, 7'h0F, sleep_pkg::W_OTHER,
             sleep_pkg::W_CONV, 0, 1);
    do_sleep(3'h2, 14'h0010, 7'h00, sleep_pkg::W_CONV, sleep_pkg::W_PCINT,
             sleep_pkg::PD_DELAY_BASE_CYC - 1, 0);
    do_sleep(3'h2, 14'h0E00, 7'h00, sleep_pkg::W_EXT_IRQ_0, sleep_pkg::W_EXT_IRQ_1,
             PD_MAX - 1, 0);
    do_sleep(3'h3, 14'h00E5, 7'h05, sleep_pkg::W_CONV, sleep_pkg::W_T2_OVF,
             sleep_pkg::PD_DELAY_BASE_CYC - 1,
             0);
    do_sleep(3'h6, 14'h0008, 7'h02, sleep_pkg::W_T2_OVF, sleep_pkg::W_WDT,
             sleep_pkg::STANDBY_CYCLES - 1, 0);
    t_reset;
    close_out;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out;
  end
endmodule
